// >>> design/fbas_device.sv
// Function
// - upper switch sixteens, lower switch units
// - raw value above 127 reads as zero
// - switch 0 or 127 selects stored parameter
// - stored address accepts only 1 to 126
// - switch 1..126 used, parameter reports it
// - switch setting readable separately
// - address change effective after power-on only
// - switches default zero, parameter used
// - valid addresses 1 to 126
// - each station address unique per line
// - block number is parameter number
// - offset splits object and sub-index
// - single values only, arrays rejected
// - master may configure longer telegram
// - unsupplied process words read zero
// - seven-entry identification array readable
`timescale 1ns/10ps
`default_nettype none
`include "fbas_defs.svh"
module fbas_device
(
  input  wire logic        clk_sys,       // 250 MHz system clock
  input  wire logic        rst_n,         // power-on reset
  input  wire logic [3:0]  switchHigh,    // sixteens rotary switch
  input  wire logic [3:0]  switchLow,     // units rotary switch
  input  wire logic [3:0]  pdSupplied,    // words the drive object supplies
  input  wire logic [15:0] pdSource [16], // drive object process words
  fbas_if.device           bus            // link to the master
);
  import fbas_pkg::*;

  // ==========================================================
  // switch decode
  // the switches are slow levels taken as synchronous to clk_sys; turning
  // them while running changes the readbacks and whether parameter writes are taken, never the address
  // the readback shows the raw setting, even one that is read as zero
  // a raw setting above the limit is folded to zero before the mode test
  logic [7:0]  rawSwitch;       // combined switch value
  logic [7:0]  effSwitch;       // value after range check
  logic        useStored;       // parameter mode
  assign rawSwitch = {switchHigh, switchLow};
  // values over 127 behave as zero
  assign effSwitch = (rawSwitch > `FBAS_SWITCH_LIMIT) ? `FBAS_SWITCH_FACTORY
                                                       : rawSwitch;
  // zero, incl. factory setting, and 127 fall back to the parameter
  assign useStored = (effSwitch[6:0] == `FBAS_ADDR_ZERO) ||
                     (effSwitch[6:0] == `FBAS_ADDR_PARAM_HI);

  // ==========================================================
  // stored address parameter
  // this register stands for a non-volatile store: rst_n does not clear it,
  // so an address written now is still there at the next power-on, which is
  // the only moment at which it can become the running address
  // the declaration value is the content of the store as it leaves the factory
  logic [6:0]  stored_q = `FBAS_STORED_RST; // stored address
  // only legal addresses are taken, and only in parameter mode;
  // writes are ignored while power-on reset is held low
  // the parameter is changed only by a legal write, never by the switches
  always_ff @(posedge clk_sys)
  begin
    if (rst_n && bus.paramWrStb && useStored &&
        bus.paramWrData >= `FBAS_ADDR_MIN &&
        bus.paramWrData <= `FBAS_ADDR_MAX)
      stored_q <= bus.paramWrData;
  end

  // ==========================================================
  // power-on address capture
  // one capture per reset keeps the bus address steady for the whole run;
  // a master that wants a new address has to power the unit up again
  logic        captured_q;      // set after first clock after release
  logic [6:0]  station_q;       // running station address
  // reset loads a constant; the real value is taken on the first edge.
  // later switch or parameter changes stay dormant until next reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      captured_q <= 1'b0;
      station_q  <= `FBAS_ADDR_ZERO;
    end
    else if (!captured_q)
    begin
      captured_q <= 1'b1;
      station_q  <= useStored ? stored_q : effSwitch[6:0];
    end
  end
  assign bus.stationAddr = station_q;

  // ==========================================================
  // readbacks
  logic [6:0]  storedRd_q;      // parameter read value
  logic [7:0]  switchRd_q;      // switch status value
  // in switch mode the parameter reports the active address
  // both readbacks lag their source by one clock, so they are settled
  // from the second edge after reset release
  // the mode is taken from the live switches, not from the captured mode
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      storedRd_q <= `FBAS_ADDR_ZERO;
      switchRd_q <= `FBAS_SWITCH_FACTORY;
    end
    else
    begin
      storedRd_q <= useStored ? stored_q : station_q;
      switchRd_q <= rawSwitch;
    end
  end
  assign bus.storedReadback = storedRd_q;
  assign bus.switchReadback = switchRd_q;

  // ==========================================================
  // panel parameter access
  logic           accAck_q;     // one-cycle answer
  fbas_ans_type   accAns_q;
  fbas_param_type accParam_q;
  // block 0 is not a parameter; only one element of a value allowed
  // the decode is pure wiring of the block number and offset fields, so
  // accepted and refused accesses cost the same single cycle; the fields
  // are kept even when the access is refused
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accAck_q   <= 1'b0;
      accAns_q   <= FBAS_ANS_NONE;
      accParam_q <= '0;
    end
    else
    begin
      accAck_q <= bus.accStb;
      if (bus.accStb)
      begin
        accParam_q.paramNum <= bus.blockNumber;
        accParam_q.objNum   <= bus.blockOffset[`FBAS_OBJ_MSB:`FBAS_OBJ_LSB];
        accParam_q.subIdx   <= bus.blockOffset[`FBAS_SUB_MSB:`FBAS_SUB_LSB];
        if (bus.accKind == FBAS_ACC_VALUE && bus.elemCount == 3'h1 &&
            bus.blockNumber != 16'h0000)
          accAns_q <= FBAS_ANS_OK;
        else
          accAns_q <= FBAS_ANS_REJ;
      end
    end
  end
  assign bus.accAck   = accAck_q;
  assign bus.accAns   = accAns_q;
  assign bus.accParam = accParam_q;

  // ==========================================================
  // identification array
  logic [15:0] identMem [`FBAS_IDENT_ENTRIES]; // fixed identification words
  logic        identAck_q;
  logic [15:0] identData_q;
  genvar gi;
  generate
    for (gi = 0; gi < `FBAS_IDENT_ENTRIES; gi++)
    begin : g_ident
      assign identMem[gi] = `FBAS_IDENT_SEED + 16'(gi);
    end
  endgenerate
  // out-of-range index reads zero
  // the seven words are fixed wiring, so they need no reset value;
  // index seven lies beyond the array and would otherwise read unknown
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      identAck_q  <= 1'b0;
      identData_q <= 16'h0000;
    end
    else
    begin
      identAck_q <= bus.identStb;
      if (bus.identStb)
        identData_q <= (bus.identIdx < 3'(`FBAS_IDENT_ENTRIES)) ?
                       identMem[bus.identIdx] : 16'h0000;
    end
  end
  assign bus.identAck  = identAck_q;
  assign bus.identData = identData_q;

  // ==========================================================
  // process data words
  logic        pdAck_q;
  logic [15:0] pdData_q;
  // any index the master configures is answered; beyond supply it is zero
  // the master may set up a longer telegram than the drive object fills;
  // zero rather than stale data keeps the unused words harmless
  // pdSupplied is a count, so at most fifteen words can be supplied
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdAck_q  <= 1'b0;
      pdData_q <= 16'h0000;
    end
    else
    begin
      pdAck_q <= bus.pdStb;
      if (bus.pdStb)
        pdData_q <= (bus.pdIdx < pdSupplied) ? pdSource[bus.pdIdx] : 16'h0000;
    end
  end
  assign bus.pdAck  = pdAck_q;
  assign bus.pdData = pdData_q;
endmodule // fbas_device
`default_nettype wire

// >>> design/fbas_defs.svh
`ifndef FBAS_DEFS_SVH
`define FBAS_DEFS_SVH
// address limits
`define FBAS_ADDR_MIN       7'h01
`define FBAS_ADDR_MAX       7'h7e
`define FBAS_ADDR_PARAM_HI  7'h7f
`define FBAS_ADDR_ZERO      7'h00
`define FBAS_SWITCH_LIMIT   8'h7f
// stored address initial value, not reloaded by reset (arbitrary default, factory parameter)
`define FBAS_STORED_RST     7'h7e
// switch factory setting
`define FBAS_SWITCH_FACTORY 8'h00
// block offset fields
`define FBAS_OBJ_MSB        15
`define FBAS_OBJ_LSB        10
`define FBAS_SUB_MSB        9
`define FBAS_SUB_LSB        0
// process data
`define FBAS_PD_WORDS       16
`define FBAS_PD_IDXW        4
// identification array
`define FBAS_IDENT_ENTRIES  7
`define FBAS_IDENT_IDXW     3
// arbitrary identification word value
`define FBAS_IDENT_SEED     16'h1000
`endif

// >>> design/fbas_pkg.sv
`default_nettype none
package fbas_pkg;
  // kind of panel access
  typedef enum logic [1:0] {
    FBAS_ACC_VALUE = 2'h0,
    FBAS_ACC_ARRAY = 2'h1,
    FBAS_ACC_DESC  = 2'h2,
    FBAS_ACC_TEXT  = 2'h3
  } fbas_acc_type;
  // decoded parameter address
  typedef struct packed {
    logic [15:0] paramNum;
    logic [5:0]  objNum;
    logic [9:0]  subIdx;
  } fbas_param_type;
  // access answer
  typedef enum logic [1:0] {
    FBAS_ANS_NONE = 2'h0,
    FBAS_ANS_OK   = 2'h1,
    FBAS_ANS_REJ  = 2'h3
  } fbas_ans_type;
endpackage
`default_nettype wire

// >>> design/fbas_if.sv
`timescale 1ns/10ps
`default_nettype none
// link between the fieldbus slave and the master / panel
interface fbas_if;
  import fbas_pkg::*;
  logic         paramWrStb;    // write stored address
  logic [6:0]   paramWrData;
  logic         accStb;        // panel access strobe
  logic [15:0]  blockNumber;   // block_number_area
  logic [15:0]  blockOffset;   // block_offset_word
  fbas_acc_type accKind;
  logic [2:0]   elemCount;
  logic         accAck;        // answer pulse
  fbas_ans_type accAns;
  fbas_param_type accParam;
  logic [6:0]   stationAddr;
  logic [6:0]   storedReadback;
  logic [7:0]   switchReadback;
  logic         identStb;
  logic [2:0]   identIdx;
  logic         identAck;
  logic [15:0]  identData;
  logic         pdStb;
  logic [3:0]   pdIdx;
  logic         pdAck;
  logic [15:0]  pdData;
  modport device (input paramWrStb, paramWrData, accStb, blockNumber, blockOffset, accKind,
                  elemCount, identStb, identIdx, pdStb, pdIdx,
                  output accAck, accAns, accParam, stationAddr, storedReadback,
                  switchReadback, identAck, identData, pdAck, pdData);
  modport master (output paramWrStb, paramWrData, accStb, blockNumber, blockOffset, accKind,
                  elemCount, identStb, identIdx, pdStb, pdIdx,
                  input accAck, accAns, accParam, stationAddr, storedReadback,
                  switchReadback, identAck, identData, pdAck, pdData);
endinterface
`default_nettype wire

// >>> design/fbas_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbas_defs.svh"
module fbas_master
(
  input  wire logic                  clk_sys,     // system clock
  input  wire logic                  rst_n,       // reset
  input  wire logic                  userAddrWr,  // request stored address write
  input  wire logic [6:0]            userAddr,    // address to store
  input  wire logic                  userAcc,     // request panel access
  input  wire logic [15:0]           userBlock,
  input  wire logic [15:0]           userOffset,
  input  wire fbas_pkg::fbas_acc_type userKind,
  input  wire logic [2:0]            userElems,
  input  wire logic                  userIdent,
  input  wire logic [2:0]            userIdentIdx,
  input  wire logic                  userPd,
  input  wire logic [3:0]            userPdIdx,
  output logic                       addrWrDropped, // illegal address not sent
  output logic [15:0]                rdData,        // last answer data
  output logic                       rdValid,       // answer pulse
  output fbas_pkg::fbas_ans_type     accResult,
  fbas_if.master                     bus
);
  import fbas_pkg::*;

  // ==========================================================
  // request drive; only legal addresses are ever written
  logic legalAddr;
  assign legalAddr = (userAddr >= `FBAS_ADDR_MIN) && (userAddr <= `FBAS_ADDR_MAX);
  assign bus.paramWrStb  = userAddrWr && legalAddr;
  assign bus.paramWrData = userAddr;
  assign bus.accStb      = userAcc;
  assign bus.blockNumber = userBlock;
  assign bus.blockOffset = userOffset;
  assign bus.accKind     = userKind;
  assign bus.elemCount   = userElems;
  assign bus.identStb    = userIdent;
  assign bus.identIdx    = userIdentIdx;
  assign bus.pdStb       = userPd;
  assign bus.pdIdx       = userPdIdx;

  // ==========================================================
  // answer capture
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrWrDropped <= 1'b0;
      rdData        <= 16'h0000;
      rdValid       <= 1'b0;
      accResult     <= FBAS_ANS_NONE;
    end
    else
    begin
      addrWrDropped <= userAddrWr && !legalAddr;
      rdValid       <= bus.identAck || bus.pdAck || bus.accAck;
      if (bus.identAck)
        rdData <= bus.identData;
      else if (bus.pdAck)
        rdData <= bus.pdData;
      if (bus.accAck)
        accResult <= bus.accAns;
    end
  end
endmodule // fbas_master
`default_nettype wire

// >>> sim/fbas_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbas_defs.svh"
// ==========================================
// link checks between master and device
module fbas_props
(
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   accStb,
  input wire logic [15:0]            blockNumber,
  input wire logic [15:0]            blockOffset,
  input wire fbas_pkg::fbas_acc_type accKind,
  input wire logic [2:0]             elemCount,
  input wire logic                   accAck,
  input wire fbas_pkg::fbas_ans_type accAns,
  input wire fbas_pkg::fbas_param_type accParam,
  input wire logic [6:0]             stationAddr,
  input wire logic                   identStb,
  input wire logic [2:0]             identIdx,
  input wire logic                   identAck,
  input wire logic [15:0]            identData,
  input wire logic                   pdStb,
  input wire logic                   pdAck
);
  import fbas_pkg::*;
  logic goodReq; // a single value of a real parameter
  assign goodReq = accStb && accKind == FBAS_ACC_VALUE && elemCount == 3'h1 && blockNumber != 16'h0;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // panel access
  a_acc_answered: assert property (accStb |=> accAck)
    else $error("access not answered");
  a_ack_has_cause: assert property (accAck |-> $past(accStb))
    else $error("answer without access");
  a_acc_refused: assert property (accStb &&
    (accKind != FBAS_ACC_VALUE || elemCount != 3'h1) |=> accAns == FBAS_ANS_REJ)
    else $error("bulk access not refused");
  a_block_zero: assert property (accStb && blockNumber == 16'h0 |=> accAns == FBAS_ANS_REJ)
    else $error("block zero accepted");
  a_acc_accepted: assert property (goodReq |=> accAns == FBAS_ANS_OK
    && accParam.paramNum == $past(blockNumber)) else $error("parameter number wrong");
  a_offset_split: assert property (goodReq |=> accParam.objNum == $past(blockOffset[15:10])
    && accParam.subIdx == $past(blockOffset[9:0])) else $error("offset split wrong");
  // ==========================================
  // station address, identification, process words
  a_addr_held: assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable(stationAddr))
    else $error("station address moved");
  a_addr_valid: assert property ($past(rst_n) |-> stationAddr >= `FBAS_ADDR_MIN
    && stationAddr <= `FBAS_ADDR_MAX) else $error("station address out of range");
  a_ident_word: assert property (identStb |=> identAck &&
    identData == (($past(identIdx) == 3'h7) ? 16'h0 : `FBAS_IDENT_SEED + 16'($past(identIdx))))
    else $error("ident word wrong");
  a_pd_answer: assert property (pdAck == $past(pdStb))
    else $error("process word answer timing");
  c_acc_ok: cover property (goodReq ##1 accAns == FBAS_ANS_OK);
  c_acc_rej: cover property (accStb && accKind != FBAS_ACC_VALUE);
  c_ident_top: cover property (identStb && identIdx == 3'h7);
  c_pd_read: cover property (pdStb ##1 pdAck);
endmodule // fbas_props
`default_nettype wire

// >>> sim/fbas_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// both ends joined, user side driven here
module fbas_bench;
  import fbas_pkg::*;
  logic         clk_sys, rst_n;
  logic [3:0]   switchHigh, switchLow, pdSupplied, userPdIdx;
  logic [15:0]  pdSource [16];      // drive object words
  logic         userAddrWr, userAcc, userIdent, userPd;
  logic [6:0]   userAddr;
  logic [15:0]  userBlock, userOffset, rdData;
  fbas_acc_type userKind;
  logic [2:0]   userElems, userIdentIdx;
  logic         rdValid, addrWrDropped;
  fbas_ans_type accResult;
  int           n_errors, checks_done;
  fbas_if bus ();
  fbas_device i_fbas_device (.clk_sys(clk_sys), .rst_n(rst_n), .switchHigh(switchHigh),
    .switchLow(switchLow), .pdSupplied(pdSupplied), .pdSource(pdSource), .bus(bus));
  fbas_master i_fbas_master (.clk_sys(clk_sys), .rst_n(rst_n), .userAddrWr(userAddrWr),
    .userAddr(userAddr), .userAcc(userAcc), .userBlock(userBlock), .userOffset(userOffset),
    .userKind(userKind), .userElems(userElems), .userIdent(userIdent),
    .userIdentIdx(userIdentIdx), .userPd(userPd), .userPdIdx(userPdIdx),
    .addrWrDropped(addrWrDropped), .rdData(rdData), .rdValid(rdValid),
    .accResult(accResult), .bus(bus));
  fbas_props i_fbas_props (.clk_sys(clk_sys), .rst_n(rst_n), .accStb(bus.accStb),
    .blockNumber(bus.blockNumber), .blockOffset(bus.blockOffset), .accKind(bus.accKind),
    .elemCount(bus.elemCount), .accAck(bus.accAck), .accAns(bus.accAns),
    .accParam(bus.accParam), .stationAddr(bus.stationAddr), .identStb(bus.identStb),
    .identIdx(bus.identIdx), .identAck(bus.identAck), .identData(bus.identData),
    .pdStb(bus.pdStb), .pdAck(bus.pdAck));
  // ==========================================
  // clock, 4 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // one comparison, four-state exact
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // power cycle with given switches; address is only taken here
  task automatic power_on(input logic [3:0] hi, input logic [3:0] lo, input logic [6:0] adr);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    switchHigh <= hi;
    switchLow <= lo;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check(32'(bus.stationAddr), 32'(adr));
    check(32'(bus.storedReadback), 32'(adr));
    check(32'(bus.switchReadback), 32'({hi, lo}));
  endtask
  // stored address write, then readback
  task automatic wr_addr(input logic [6:0] a, input logic [6:0] exp);
    @(posedge clk_sys);
    userAddrWr <= 1'b1;
    userAddr <= a;
    @(posedge clk_sys);
    userAddrWr <= 1'b0;
    @(negedge clk_sys);
    check(32'(addrWrDropped), 32'(a < 7'h01 || a > 7'h7e));
    repeat (2) @(negedge clk_sys);
    check(32'(bus.storedReadback), 32'(exp));
  endtask
  // one panel access; answer one cycle after the strobe edge
  task automatic acc(input logic [15:0] b, input logic [15:0] o, input fbas_acc_type k,
                     input logic [2:0] n, input fbas_ans_type ans);
    @(posedge clk_sys);
    userAcc <= 1'b1;
    {userBlock, userOffset, userKind, userElems} <= {b, o, k, n};
    @(posedge clk_sys);
    userAcc <= 1'b0;
    @(negedge clk_sys);
    check(32'(bus.accAck), 32'h1);
    check(32'(bus.accAns), 32'(ans));
    if (ans == FBAS_ANS_OK)
      check(bus.accParam, {b, o});
    @(negedge clk_sys);
    check(32'({rdValid, accResult}), 32'({1'b1, ans}));
  endtask
  // identification or process word read
  task automatic rd_word(input logic isPd, input logic [3:0] idx, input logic [15:0] exp);
    @(posedge clk_sys);
    {userPd, userIdent, userPdIdx, userIdentIdx} <= {isPd, !isPd, idx, idx[2:0]};
    @(posedge clk_sys);
    {userPd, userIdent} <= 2'h0;
    @(negedge clk_sys);
    check(32'(isPd ? bus.pdData : bus.identData), 32'(exp));
    @(negedge clk_sys);
    check(32'({rdValid, rdData}), 32'({1'b1, exp}));
  endtask
  // ==========================================
  // watchdog, far above the real run length
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    {rst_n, switchHigh, switchLow, userAddrWr, userAcc, userIdent, userPd} = '0;
    {userAddr, userBlock, userOffset, userElems, userIdentIdx, userPdIdx} = '0;
    userKind = FBAS_ACC_VALUE;
    pdSupplied = 4'h3; // fewer words than the telegram carries
    n_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 16; i++)
      pdSource[i] = 16'ha000 + 16'(i);
    power_on(4'h0, 4'h0, 7'h7e);
    wr_addr(7'h05, 7'h05);
    check(32'(bus.stationAddr), 32'h7e);
    wr_addr(7'h00, 7'h05);
    wr_addr(7'h7f, 7'h05);
    wr_addr(7'h01, 7'h01);
    acc(16'h1234, {6'h2a, 10'h3ff}, FBAS_ACC_VALUE, 3'h1, FBAS_ANS_OK);
    acc(16'hffff, {6'h3f, 10'h000}, FBAS_ACC_VALUE, 3'h1, FBAS_ANS_OK);
    acc(16'h0001, 16'h0000, FBAS_ACC_VALUE, 3'h1, FBAS_ANS_OK);
    acc(16'h0000, 16'h0000, FBAS_ACC_VALUE, 3'h1, FBAS_ANS_REJ);
    acc(16'h0010, 16'h0001, FBAS_ACC_VALUE, 3'h2, FBAS_ANS_REJ);
    for (int k = 1; k < 4; k++)
      acc(16'h0010, 16'h0001, fbas_acc_type'(k), 3'h1, FBAS_ANS_REJ);
    for (int i = 0; i < 8; i++)
      rd_word(1'b0, 4'(i), (i < 7) ? 16'h1000 + 16'(i) : 16'h0);
    for (int i = 0; i < 16; i++)
      rd_word(1'b1, 4'(i), (i < 3) ? 16'ha000 + 16'(i) : 16'h0);
    @(posedge clk_sys);
    pdSupplied <= 4'ha; // a drive object that fills more words
    rd_word(1'b1, 4'h9, 16'ha009);
    rd_word(1'b1, 4'ha, 16'h0000);
    power_on(4'h1, 4'h5, 7'h15);
    wr_addr(7'h09, 7'h15);
    @(posedge clk_sys);
    switchHigh <= 4'h2; // turned while running, must not move the address
    switchLow <= 4'h3;
    repeat (3) @(negedge clk_sys);
    check(32'(bus.stationAddr), 32'h15);
    check(32'(bus.switchReadback), 32'h23);
    power_on(4'h7, 4'hf, 7'h01);
    power_on(4'h8, 4'h5, 7'h01);
    power_on(4'h7, 4'he, 7'h7e);
    end_of_test();
  end
endmodule // fbas_bench
`default_nettype wire
